//--- rtl/ars_timer_defs.svh
`ifndef ARS_TIMER_DEFS_SVH
`define ARS_TIMER_DEFS_SVH

// Register offsets on the special function register bus.
`define ARS_ADDR_CTRL 8'hc8
`define ARS_ADDR_RL_LO 8'hca
`define ARS_ADDR_RL_HI 8'hcb
`define ARS_ADDR_CNT_LO 8'hcc
`define ARS_ADDR_CNT_HI 8'hcd

// Reset values.
`define ARS_RST_BYTE 8'h00

// Control register field positions.
`define ARS_BIT_HI_OVF 7
`define ARS_BIT_LO_OVF 6
`define ARS_BIT_LO_IRQ_EN 5
`define ARS_BIT_CAP_EN 4
`define ARS_BIT_SPLIT 3
`define ARS_BIT_RUN 2
`define ARS_BIT_UNUSED 1
`define ARS_BIT_ALT_CLK 0
`define ARS_CTRL_WMASK 8'hfd

// Divider ratios, then the same ratios written as the last count of each divider.
`define ARS_SYS_DIV 12
`define ARS_EXT_DIV 8
`define ARS_SYS_DIV_LAST 4'hb
`define ARS_EXT_DIV_LAST 3'h7

// Byte and word limits.
`define ARS_BYTE_MAX 8'hff
`define ARS_WORD_MAX 16'hffff

`endif

//--- rtl/ars_pkg.sv
package ars_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ars_sfr_s;

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic lfo_capture_enable;
        logic split_mode_select;
        logic run_control;
        logic unused;
        logic alt_clock_select;
    } ars_ctrl_s;

    typedef struct packed {
        ars_ctrl_s ctrl;
        logic [7:0] reload_low;
        logic [7:0] reload_high;
        logic [7:0] count_low;
        logic [7:0] count_high;
        logic [7:0] rdata;
        logic irq;
        logic lfo_prev;
    } ars_state_s;

    typedef struct packed {
        logic [3:0] sys_cnt;
        logic [2:0] ext_cnt;
        logic ext_prev;
        logic sys_en;
        logic ext_en;
    } ars_div_s;

    typedef struct packed {
        logic [1:0] ff;
    } ars_sync_s;

endpackage

//--- rtl/ars_sync.sv
`timescale 1ns/100ps

module ars_sync
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Asynchronous level in, synchronous level out
    input wire logic async_i,
    output logic sync_o
);
    import ars_pkg::*;

    ars_sync_s s_q;
    ars_sync_s s_d;

    // The first stage feeds only the second stage.
    always_comb
    begin
        s_d = '{ff: {s_q.ff[0], async_i}};
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sync_o = s_q.ff[1];

endmodule // ars_sync

//--- rtl/ars_clk_div.sv
`timescale 1ns/100ps
`include "ars_timer_defs.svh"

module ars_clk_div
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Synchronised external oscillator level
    input wire logic ext_sync_i,
    // One-cycle enable pulses
    output logic sys_div_en_o,
    output logic ext_div_en_o
);
    import ars_pkg::*;

    ars_div_s s_q;
    ars_div_s s_d;

    // The external clock is counted by its rising edges seen at the system clock,
    // so it must run well below half the system clock rate.
    always_comb
    begin
        s_d = s_q;
        s_d.sys_en = 1'b0;
        s_d.ext_en = 1'b0;
        s_d.ext_prev = ext_sync_i;
        if (s_q.sys_cnt == `ARS_SYS_DIV_LAST)
        begin
            s_d.sys_cnt = 4'h0;
            s_d.sys_en = 1'b1;
        end
        else
        begin
            s_d.sys_cnt = s_q.sys_cnt + 4'h1;
        end
        if (ext_sync_i && !s_q.ext_prev)
        begin
            s_d.ext_cnt = s_q.ext_cnt + 3'h1;
            s_d.ext_en = (s_q.ext_cnt == `ARS_EXT_DIV_LAST);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sys_div_en_o = s_q.sys_en;
    assign ext_div_en_o = s_q.ext_en;

endmodule // ars_clk_div

//--- rtl/ars_timer.sv
// Notes on behaviour
// RQ1 - The high flag sets when the high byte rolls from 0xff to 0, in 16-bit mode at 0xffff.
// RQ2 - The overflow flags are never cleared by hardware; only a software write clears them.
// RQ3 - The low overflow flag sets whenever the low byte rolls from 0xff to 0, in either mode.
// RQ4 - The low flag requests an interrupt only when its enable and the timer enable are set.
// RQ5 - With capture and irq enabled, a falling slow edge copies the count and requests an irq.
// RQ6 - Split select zero gives one 16-bit reload timer, one gives two 8-bit reload timers.
// RQ7 - Run control gates the whole counter in 16-bit mode but only the high byte in split mode.
// RQ8 - Control bit 1 always reads zero and ignores writes.
// RQ9 - Alternate clock select zero picks the system clock / 12, one the external clock / 8.
// RQ10 - In 16-bit mode a 0xffff rollover loads the reload pair and sets the high overflow flag.
// RQ11 - In 16-bit mode an irq fires on each full overflow, and on low rollover if enabled.
// RQ12 - In split mode each byte reloads from its own reload register on overflow.
// RQ13 - In split mode a byte runs on the system clock if its select is one, else the alternate.
// RQ14 - In split mode an irq fires on high overflow, and on either one if low enable is set.
// RQ15 - The high select matters only in split mode; in 16-bit mode the low select clocks all.
// RQ16 - A running counter steps once per enable pulse; a count write takes effect at once.
`timescale 1ns/100ps
`include "ars_timer_defs.svh"

module ars_timer
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Special function register bus
    input wire ars_pkg::ars_sfr_s sfr_i,
    output logic [7:0] sfr_rdata_o,
    // Clock selects and interrupt enable held elsewhere in the core
    input wire logic low_byte_clock_select_i,
    input wire logic high_byte_clock_select_i,
    input wire logic timer_irq_enable_i,
    // Asynchronous oscillator inputs
    input wire logic ext_osc_i,
    input wire logic lfo_i,
    // Interrupt request
    output logic irq_o
);
    import ars_pkg::*;

    ars_state_s s_q;
    ars_state_s s_d;

    logic ext_sync;
    logic lfo_sync;
    logic sys_div_en;
    logic ext_div_en;
    logic alt_en;
    logic lo_en;
    logic hi_en;
    logic tick_lo;
    logic tick_hi;
    logic lfo_fall;
    logic set_hi;
    logic set_lo;
    logic wr_ctrl;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_rl_lo;
    logic wr_rl_hi;
    logic [15:0] count16;
    logic [15:0] count16_inc;

    function automatic logic at_max(input logic [7:0] value);
        return value == `ARS_BYTE_MAX;
    endfunction

    function automatic logic hit(input ars_sfr_s req, input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    ars_sync u_ext_sync
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(ext_osc_i),
        .sync_o(ext_sync)
    );

    ars_sync u_lfo_sync
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(lfo_i),
        .sync_o(lfo_sync)
    );

    ars_clk_div u_clk_div
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ext_sync_i(ext_sync),
        .sys_div_en_o(sys_div_en),
        .ext_div_en_o(ext_div_en)
    );

    always_comb
    begin
        alt_en = s_q.ctrl.alt_clock_select ? ext_div_en : sys_div_en; // RQ9
        lo_en = low_byte_clock_select_i ? 1'b1 : alt_en; // RQ13 RQ15
        hi_en = high_byte_clock_select_i ? 1'b1 : alt_en; // RQ13
        if (s_q.ctrl.split_mode_select)
        begin
            tick_lo = lo_en; // RQ7
            tick_hi = s_q.ctrl.run_control && hi_en; // RQ7
        end
        else
        begin
            tick_lo = s_q.ctrl.run_control && lo_en; // RQ7 RQ15
            tick_hi = 1'b0;
        end
        lfo_fall = s_q.lfo_prev && !lfo_sync;
        wr_ctrl = hit(sfr_i, `ARS_ADDR_CTRL);
        wr_cnt_lo = hit(sfr_i, `ARS_ADDR_CNT_LO);
        wr_cnt_hi = hit(sfr_i, `ARS_ADDR_CNT_HI);
        wr_rl_lo = hit(sfr_i, `ARS_ADDR_RL_LO);
        wr_rl_hi = hit(sfr_i, `ARS_ADDR_RL_HI);
        count16 = {s_q.count_high, s_q.count_low};
        count16_inc = count16 + 16'h0001;
    end

    always_comb
    begin
        s_d = s_q;
        set_hi = 1'b0;
        set_lo = 1'b0;
        s_d.lfo_prev = lfo_sync;

        if (!s_q.ctrl.split_mode_select)
        begin
            // One 16-bit counter.
            if (tick_lo) // RQ6 RQ16
            begin
                set_lo = at_max(s_q.count_low); // RQ3 RQ11
                if (count16 == `ARS_WORD_MAX)
                begin
                    {s_d.count_high, s_d.count_low} = {s_q.reload_high, s_q.reload_low}; // RQ10
                    set_hi = 1'b1; // RQ1 RQ10
                end
                else
                begin
                    {s_d.count_high, s_d.count_low} = count16_inc; // RQ16
                end
            end
        end
        else
        begin
            // Two independent 8-bit counters.
            if (tick_lo) // RQ6
            begin
                set_lo = at_max(s_q.count_low); // RQ3
                s_d.count_low = set_lo ? s_q.reload_low : s_q.count_low + 8'h01; // RQ12
            end
            if (tick_hi)
            begin
                set_hi = at_max(s_q.count_high); // RQ1
                s_d.count_high = set_hi ? s_q.reload_high : s_q.count_high + 8'h01; // RQ12
            end
        end

        // A capture reports itself through the high overflow flag, since no flag of
        // its own exists; a software reload write in the same cycle wins.
        if (lfo_fall && s_q.ctrl.lfo_capture_enable && timer_irq_enable_i)
        begin
            s_d.reload_high = s_q.count_high; // RQ5
            s_d.reload_low = s_q.count_low; // RQ5
            set_hi = 1'b1; // RQ5
        end

        if (wr_ctrl)
            s_d.ctrl = ars_ctrl_s'(sfr_i.wdata & `ARS_CTRL_WMASK); // RQ8
        if (wr_rl_lo)
            s_d.reload_low = sfr_i.wdata;
        if (wr_rl_hi)
            s_d.reload_high = sfr_i.wdata;
        if (wr_cnt_lo)
            s_d.count_low = sfr_i.wdata; // RQ16
        if (wr_cnt_hi)
            s_d.count_high = sfr_i.wdata; // RQ16

        // Hardware only sets the flags, and a set beats a clear in the same cycle.
        s_d.ctrl.high_overflow_flag = s_d.ctrl.high_overflow_flag || set_hi; // RQ2
        s_d.ctrl.low_overflow_flag = s_d.ctrl.low_overflow_flag || set_lo; // RQ2

        s_d.irq = timer_irq_enable_i && (s_q.ctrl.high_overflow_flag // RQ11 RQ14
            || (s_q.ctrl.low_overflow_flag && s_q.ctrl.low_overflow_irq_enable)); // RQ4

        if (sfr_i.rd)
        begin
            case (sfr_i.addr)
                `ARS_ADDR_CTRL: s_d.rdata = s_q.ctrl & `ARS_CTRL_WMASK; // RQ8
                `ARS_ADDR_RL_LO: s_d.rdata = s_q.reload_low;
                `ARS_ADDR_RL_HI: s_d.rdata = s_q.reload_high;
                `ARS_ADDR_CNT_LO: s_d.rdata = s_q.count_low;
                `ARS_ADDR_CNT_HI: s_d.rdata = s_q.count_high;
                default: s_d.rdata = `ARS_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sfr_rdata_o = s_q.rdata;
    assign irq_o = s_q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    AST_HIGH_OVF_16: assert property ( // RQ1
        !s_q.ctrl.split_mode_select && tick_lo && count16 == `ARS_WORD_MAX
        |=> s_q.ctrl.high_overflow_flag)
        else $error("High flag missed on 16-bit rollover.");

    AST_FLAG_HOLD: assert property ( // RQ2
        s_q.ctrl.high_overflow_flag && s_q.ctrl.low_overflow_flag && !wr_ctrl
        |=> s_q.ctrl.high_overflow_flag && s_q.ctrl.low_overflow_flag)
        else $error("Overflow flag cleared without a write.");

    AST_LOW_OVF: assert property ( // RQ3
        tick_lo && s_q.count_low == `ARS_BYTE_MAX |=> s_q.ctrl.low_overflow_flag)
        else $error("Low flag missed on low byte rollover.");

    AST_LOW_IRQ_MASK: assert property ( // RQ4
        !s_q.ctrl.high_overflow_flag && !s_q.ctrl.low_overflow_irq_enable
        |=> !irq_o)
        else $error("Low overflow raised a masked interrupt.");

    AST_CAPTURE: assert property ( // RQ5
        lfo_fall && s_q.ctrl.lfo_capture_enable && timer_irq_enable_i
        && !wr_rl_lo && !wr_rl_hi
        |=> {s_q.reload_high, s_q.reload_low} == $past(count16)
        && s_q.ctrl.high_overflow_flag)
        else $error("Capture did not copy the count.");

    AST_RUN_GATE: assert property ( // RQ7
        !s_q.ctrl.split_mode_select && !s_q.ctrl.run_control
        && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl
        |=> $stable(count16))
        else $error("Stopped 16-bit counter moved.");

    AST_SPLIT_LOW_FREE: assert property ( // RQ7
        s_q.ctrl.split_mode_select && !s_q.ctrl.run_control && lo_en
        && s_q.count_low != `ARS_BYTE_MAX && !wr_cnt_lo && !wr_cnt_hi
        |=> s_q.count_low == $past(s_q.count_low) + 8'h01 && $stable(s_q.count_high))
        else $error("Split low byte not free running.");

    AST_BIT1_ZERO: assert property ( // RQ8
        sfr_i.rd && sfr_i.addr == `ARS_ADDR_CTRL |=> !sfr_rdata_o[`ARS_BIT_UNUSED])
        else $error("Unused control bit read as one.");

    AST_RELOAD_16: assert property ( // RQ10
        !s_q.ctrl.split_mode_select && tick_lo && count16 == `ARS_WORD_MAX
        && !wr_cnt_lo && !wr_cnt_hi
        |=> count16 == $past({s_q.reload_high, s_q.reload_low}))
        else $error("16-bit reload value wrong.");

    AST_IRQ_FULL: assert property ( // RQ11
        s_q.ctrl.high_overflow_flag && timer_irq_enable_i |=> irq_o)
        else $error("Interrupt missing for high overflow.");

    AST_SPLIT_RELOAD_HI: assert property ( // RQ12
        s_q.ctrl.split_mode_select && tick_hi && s_q.count_high == `ARS_BYTE_MAX
        && !wr_cnt_hi
        |=> s_q.count_high == $past(s_q.reload_high) && s_q.ctrl.high_overflow_flag)
        else $error("Split high byte reload wrong.");

    AST_SPLIT_SYSCLK_HI: assert property ( // RQ13
        s_q.ctrl.split_mode_select && s_q.ctrl.run_control
        && high_byte_clock_select_i && s_q.count_high != `ARS_BYTE_MAX && !wr_cnt_hi
        |=> s_q.count_high == $past(s_q.count_high) + 8'h01)
        else $error("High byte not on system clock.");

    COV_FULL_OVF: cover property (
        !s_q.ctrl.split_mode_select && tick_lo && count16 == `ARS_WORD_MAX);
    COV_SPLIT_BOTH: cover property (
        s_q.ctrl.split_mode_select && tick_lo && tick_hi);
    COV_CAPTURE: cover property (
        lfo_fall && s_q.ctrl.lfo_capture_enable && timer_irq_enable_i);
    COV_SET_VS_CLEAR: cover property (wr_ctrl && set_hi);

endmodule // ars_timer

//--- tb/ars_core_model.sv
`timescale 1ns/100ps

module ars_core_model
(
    // Clock
    input wire logic clk_i,
    // Register bus towards the timer
    output ars_pkg::ars_sfr_s sfr_o,
    input wire logic [7:0] rdata_i,
    // Selects held in the core and oscillator pins
    output logic lsel_o,
    output logic hsel_o,
    output logic irq_en_o,
    output logic ext_osc_o,
    output logic lfo_o
);
    import ars_pkg::*;

    initial
    begin
        sfr_o = '0;
        lsel_o = 1'b0;
        hsel_o = 1'b0;
        irq_en_o = 1'b0;
        ext_osc_o = 1'b0;
        lfo_o = 1'b1;
    end

    // Data is inverted after the strobe so a stale value is never mistaken for a write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk_i);
        #1;
        sfr_o.wr = 1'b0;
        sfr_o.wdata = ~d;
    endtask

    // Data is taken one full cycle after the strobe edge, so either registering edge works.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk_i);
        #1;
        sfr_o.rd = 1'b0;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask

    // The oscillator runs at a rate unrelated to the system clock.
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            ext_osc_o = 1'b1;
            #23;
            ext_osc_o = 1'b0;
            #23;
        end
    endtask

    task automatic lfo_fall();
        lfo_o = 1'b0;
        #200;
        lfo_o = 1'b1;
        #100;
    endtask
endmodule // ars_core_model

//--- tb/tb.sv
`timescale 1ns/100ps
`include "ars_timer_defs.svh"

module tb;
    import ars_pkg::*;

    localparam logic [7:0] CT = `ARS_ADDR_CTRL;
    localparam logic [7:0] RL = `ARS_ADDR_RL_LO;
    localparam logic [7:0] RH = `ARS_ADDR_RL_HI;
    localparam logic [7:0] CL = `ARS_ADDR_CNT_LO;
    localparam logic [7:0] CH = `ARS_ADDR_CNT_HI;

    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    ars_sfr_s sfr;
    logic [7:0] rdata;
    logic lsel, hsel, irq_en, ext_osc, lfo, irq;
    logic [7:0] v;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    ars_core_model i_core (.clk_i(clk_i), .sfr_o(sfr), .rdata_i(rdata), .lsel_o(lsel),
        .hsel_o(hsel), .irq_en_o(irq_en), .ext_osc_o(ext_osc), .lfo_o(lfo));

    ars_timer i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
        .low_byte_clock_select_i(lsel), .high_byte_clock_select_i(hsel),
        .timer_irq_enable_i(irq_en), .ext_osc_i(ext_osc), .lfo_i(lfo), .irq_o(irq));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        i_core.rd(a, v);
        chk(n, e, v);
    endtask

    // Used where the exact count depends on divider phase.
    task automatic rrange(input string n, input logic [7:0] a, input logic [7:0] lo,
        input logic [7:0] hi);
        i_core.rd(a, v);
        checks_done++;
        if ((v >= lo) !== 1'b1 || (v <= hi) !== 1'b1)
        begin
            fails++;
            $display("mismatch %s expected %h to %h seen %h", n, lo, hi, v);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        wait_clk(5);
        rstn_i = 1'b1;
        rchk("ctrl reset", CT, 8'h00);
        rchk("reload low reset", RL, 8'h00);
        rchk("reload high reset", RH, 8'h00);
        rchk("count low reset", CL, 8'h00);
        rchk("count high reset", CH, 8'h00);
        rchk("unmapped", 8'hc9, 8'h00);
        i_core.wr(CT, 8'h02);
        rchk("unused bit", CT, 8'h00);
        // Full 16-bit rollover on the system clock.
        i_core.lsel_o = 1'b1;
        i_core.wr(RH, 8'h12);
        i_core.wr(RL, 8'h34);
        i_core.wr(CH, 8'hff);
        i_core.wr(CL, 8'hfe);
        i_core.wr(CT, 8'h04);
        wait_clk(4);
        rchk("ctrl after rollover", CT, 8'hc4);
        chk("irq disabled", 8'h00, {7'h00, irq});
        rchk("count high reloaded", CH, 8'h12);
        i_core.irq_en_o = 1'b1;
        wait_clk(3);
        chk("irq on overflow", 8'h01, {7'h00, irq});
        wait_clk(50);
        rchk("flags kept", CT, 8'hc4);
        i_core.wr(CT, 8'h00);
        wait_clk(3);
        chk("irq after clear", 8'h00, {7'h00, irq});
        // Low byte rollover with its interrupt masked, then enabled.
        i_core.wr(CH, 8'h00);
        i_core.wr(CL, 8'hfe);
        i_core.wr(CT, 8'h04);
        wait_clk(4);
        rchk("low flag only", CT, 8'h44);
        chk("low irq masked", 8'h00, {7'h00, irq});
        i_core.wr(CT, 8'h64);
        wait_clk(3);
        chk("low irq enabled", 8'h01, {7'h00, irq});
        i_core.wr(CT, 8'h00);
        rchk("carry into high", CH, 8'h01);
        // Split mode: low byte free running, high byte gated by run.
        i_core.wr(RL, 8'h50);
        i_core.wr(RH, 8'h77);
        i_core.wr(CL, 8'hfe);
        i_core.wr(CH, 8'hfe);
        i_core.wr(CT, 8'h08);
        wait_clk(6);
        rchk("split low flag", CT, 8'h48);
        chk("split low masked", 8'h00, {7'h00, irq});
        rchk("high stopped", CH, 8'hfe);
        rrange("low reloaded", CL, 8'h50, 8'h70);
        i_core.hsel_o = 1'b1;
        i_core.wr(CT, 8'h0c);
        wait_clk(6);
        rchk("split high flag", CT, 8'h8c);
        chk("split high irq", 8'h01, {7'h00, irq});
        i_core.wr(CT, 8'h08);
        // Reload 0x77 plus nine system clock ticks before the stopping write lands.
        rchk("high reloaded", CH, 8'h80);
        // 16-bit mode on system clock / 12; high select must not matter.
        i_core.lsel_o = 1'b0;
        i_core.wr(CL, 8'h00);
        i_core.wr(CT, 8'h04);
        wait_clk(120);
        i_core.wr(CT, 8'h00);
        rrange("div12 count", CL, 8'h09, 8'h0c);
        // External oscillator / 8.
        i_core.wr(CL, 8'h00);
        i_core.wr(CT, 8'h05);
        i_core.ext_pulses(32);
        i_core.wr(CT, 8'h01);
        rrange("ext div8 count", CL, 8'h03, 8'h04);
        // Capture on a falling low-frequency edge.
        i_core.lsel_o = 1'b1;
        i_core.irq_en_o = 1'b0;
        i_core.wr(CH, 8'h40);
        i_core.wr(CL, 8'h00);
        i_core.wr(RH, 8'h00);
        i_core.wr(CT, 8'h14);
        i_core.lfo_fall();
        rchk("no capture", RH, 8'h00);
        rchk("no capture flag", CT, 8'h14);
        i_core.irq_en_o = 1'b1;
        i_core.lfo_fall();
        rchk("capture flag", CT, 8'h94);
        rchk("captured high", RH, 8'h40);
        chk("capture irq", 8'h01, {7'h00, irq});
        stop_test();
    end
endmodule // tb
